// ---- core/alert_summary_pkg.sv ----
package alert_summary_pkg;

    // Register map and field layout of the summary word
    localparam logic [7:0] PRIMARY_ALERT_SUMMARY_ADDR = 8'h02;
    localparam int REG_W = 16;
    localparam int BIT_SCAN_COMPLETE = 15;
    localparam int BIT_RESET_EVENT = 14;
    localparam int BIT_CELL_MISMATCH = 13;
    localparam int BIT_CELL_OVER = 12;
    localparam int BIT_CELL_UNDER = 11;
    localparam int BIT_BLOCK_OVER = 10;
    localparam int BIT_BLOCK_UNDER = 9;
    localparam int BIT_AUX_OVER = 8;
    localparam int BIT_AUX_UNDER = 7;
    localparam int BIT_UNUSED = 6;
    localparam int BIT_PACKET_CHECK = 5;
    localparam int BIT_INTERFACE = 4;
    localparam int BIT_CALIBRATION = 3;
    localparam int BIT_BALANCING = 2;
    localparam int BIT_DIAG_TWO = 1;
    localparam int BIT_DIAG_ONE = 0;

    // Values after power-on reset
    localparam logic [15:0] PRIMARY_ALERT_SUMMARY_RESET = 16'h4000;
    localparam logic RESET_EVENT_RESET = 1'b1;
    localparam logic ALERT_RESET = 1'b0;
    localparam logic [15:0] RDATA_RESET = 16'h0000;

    // Documented channel counts and field widths
    localparam int NUM_CELLS = 14;
    localparam int NUM_AUX = 6;
    localparam int CELL_W = 14;
    localparam int BLOCK_W = 16;
    localparam int DIAG_W = 16;

    typedef struct packed {
        logic scan_complete;
        logic reset_event;
        logic cell_mismatch;
        logic block_over;
        logic block_under;
        logic packet_check;
        logic interface_err;
        logic calibration;
        logic balancing;
        logic diag_two;
        logic diag_one;
        logic rvalid;
        logic [15:0] rdata;
    } summary_state_t;

    typedef struct packed {
        logic flag;
    } latch_state_t;

endpackage : alert_summary_pkg

// ---- core/alert_summary_latch.sv ----
`timescale 1ns/10ps
`default_nettype none

// Summary that sets as soon as any source alert is high and only drops at an
// acquisition that finds every source resolved.
module alert_summary_latch #(
    parameter int W = 14
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Source alerts from both measurement paths
    input wire logic [W-1:0] src_adc_i,
    input wire logic [W-1:0] src_cmp_i,
    input wire logic acq_done_i,
    // Summary
    output logic flag_o
);
    import alert_summary_pkg::*;

    latch_state_t state_reg;
    latch_state_t state_next;
    logic any_src;

    assign any_src = (|src_adc_i) | (|src_cmp_i);

    always_comb begin
        state_next = state_reg;
        if (any_src) begin
            state_next.flag = 1'b1;
        end else if (acq_done_i) begin
            state_next.flag = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= '{flag: ALERT_RESET};
        end else begin
            state_reg <= state_next;
        end
    end

    assign flag_o = state_reg.flag;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    summary_or_a: assert property (any_src |=> flag_o) // R8
        else $error("summary missed an active source alert");
    summary_clear_a: assert property ($fell(flag_o) |-> $past(acq_done_i) && !$past(any_src)) // R10
        else $error("summary cleared outside an acquisition or with a source active");

endmodule : alert_summary_latch

`default_nettype wire

// ---- core/primary_alert_summary.sv ----
// Notes on behaviour
// R1: Bit 15 reads 1 after a requested measurement finishes, else 0; resets to 0.
// R2: Bit 15 clears when the scan done indication drops; host writes ignored.
// R3: Bit 14 is set by every power-on reset, reset value 1.
// R4: Bit 14 clears only on a host write of 0; writing 1 changes nothing.
// R5: Host should clear bit 14 after power-up and after address enumeration.
// R6: Bit 13 sets when highest minus lowest cell voltage exceeds mismatch threshold.
// R7: Bit 13 re-evaluated at next acquisition, clears if gone; host writes ignored.
// R8: Bit 12 is OR of fourteen ADC and fourteen comparator cell over alerts.
// R9: Bit 11 is OR of fourteen ADC and fourteen comparator cell under alerts.
// R10: Bits 12 and 11 clear at next acquisition only when all sources resolved.
// R11: Bit 10 sets when latest block voltage is above block over threshold.
// R12: Bit 9 sets when latest block voltage is below block under threshold.
// R13: Block alerts re-evaluated only at next block acquisition; read-only.
// R14: Read-only summaries for aux, packet check, interface, calibration, balancing, diagnostics.
// R15: Bit 8 is OR of six ADC and six comparator aux over alerts.
// R16: Each diagnostic summary is OR of all sixteen bits of its register.
// R17: Bit 6 reads 0; writes to it and read-only bits are ignored.
// R18: All alerts other than bit 14 hold 0 after reset until set.
`timescale 1ns/10ps
`default_nettype none

module primary_alert_summary #(
    parameter int CELLS = alert_summary_pkg::NUM_CELLS,
    parameter int AUXS = alert_summary_pkg::NUM_AUX,
    parameter int CW = alert_summary_pkg::CELL_W,
    parameter int BW = alert_summary_pkg::BLOCK_W
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Register access port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [alert_summary_pkg::REG_W-1:0] reg_wdata_i,
    output logic [alert_summary_pkg::REG_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Scan control
    input wire logic scan_done_indication_i,
    // Cell acquisition
    input wire logic acq_done_i,
    input wire logic [CW-1:0] cell_max_i,
    input wire logic [CW-1:0] cell_min_i,
    input wire logic [CW-1:0] mismatch_threshold_i,
    input wire logic [CELLS:1] adc_cell_over_alerts_i,
    input wire logic [CELLS:1] comparator_cell_over_alerts_i,
    input wire logic [CELLS:1] adc_cell_under_alerts_i,
    input wire logic [CELLS:1] comparator_cell_under_alerts_i,
    input wire logic [AUXS-1:0] adc_aux_over_alerts_i,
    input wire logic [AUXS-1:0] comparator_aux_over_alerts_i,
    input wire logic [AUXS-1:0] adc_aux_under_alerts_i,
    input wire logic [AUXS-1:0] comparator_aux_under_alerts_i,
    // Block acquisition
    input wire logic block_acq_done_i,
    input wire logic [BW-1:0] block_voltage_i,
    input wire logic [BW-1:0] block_over_threshold_i,
    input wire logic [BW-1:0] block_under_threshold_i,
    // Other alert groups
    input wire logic packet_check_alert_i,
    input wire logic interface_error_alert_i,
    input wire logic calibration_fault_alert_i,
    input wire logic balancing_alert_i,
    input wire logic [alert_summary_pkg::DIAG_W-1:0] diag_group_one_register_i,
    input wire logic [alert_summary_pkg::DIAG_W-1:0] diag_group_two_register_i,
    // Live register contents
    output logic [alert_summary_pkg::REG_W-1:0] primary_alert_summary_o
);
    import alert_summary_pkg::*;

    summary_state_t state_reg;
    summary_state_t state_next;
    logic cell_over_summary;
    logic cell_under_summary;
    logic aux_over_summary;
    logic aux_under_summary;
    logic mismatch_cond;
    logic addr_hit;
    logic [REG_W-1:0] summary_word;

    // Cell and aux summaries share one latch structure
    alert_summary_latch #(.W(CELLS)) u_cell_over (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .src_adc_i(adc_cell_over_alerts_i),
        .src_cmp_i(comparator_cell_over_alerts_i),
        .acq_done_i(acq_done_i),
        .flag_o(cell_over_summary)
    ); // R8 R10

    alert_summary_latch #(.W(CELLS)) u_cell_under (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .src_adc_i(adc_cell_under_alerts_i),
        .src_cmp_i(comparator_cell_under_alerts_i),
        .acq_done_i(acq_done_i),
        .flag_o(cell_under_summary)
    ); // R9 R10

    alert_summary_latch #(.W(AUXS)) u_aux_over (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .src_adc_i(adc_aux_over_alerts_i),
        .src_cmp_i(comparator_aux_over_alerts_i),
        .acq_done_i(acq_done_i),
        .flag_o(aux_over_summary)
    ); // R15

    alert_summary_latch #(.W(AUXS)) u_aux_under (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .src_adc_i(adc_aux_under_alerts_i),
        .src_cmp_i(comparator_aux_under_alerts_i),
        .acq_done_i(acq_done_i),
        .flag_o(aux_under_summary)
    ); // R14

    // A reversed min/max pair never counts as a mismatch, so a stale
    // record cannot raise the alert through unsigned wrap-around
    assign mismatch_cond = (cell_max_i > cell_min_i) &&
        ((cell_max_i - cell_min_i) > mismatch_threshold_i); // R6

    assign addr_hit = (reg_addr_i == PRIMARY_ALERT_SUMMARY_ADDR);

    always_comb begin
        summary_word = '0;
        summary_word[BIT_SCAN_COMPLETE] = state_reg.scan_complete;
        summary_word[BIT_RESET_EVENT] = state_reg.reset_event;
        summary_word[BIT_CELL_MISMATCH] = state_reg.cell_mismatch;
        summary_word[BIT_CELL_OVER] = cell_over_summary;
        summary_word[BIT_CELL_UNDER] = cell_under_summary;
        summary_word[BIT_BLOCK_OVER] = state_reg.block_over;
        summary_word[BIT_BLOCK_UNDER] = state_reg.block_under;
        summary_word[BIT_AUX_OVER] = aux_over_summary;
        summary_word[BIT_AUX_UNDER] = aux_under_summary;
        summary_word[BIT_UNUSED] = 1'b0; // R17
        summary_word[BIT_PACKET_CHECK] = state_reg.packet_check;
        summary_word[BIT_INTERFACE] = state_reg.interface_err;
        summary_word[BIT_CALIBRATION] = state_reg.calibration;
        summary_word[BIT_BALANCING] = state_reg.balancing;
        summary_word[BIT_DIAG_TWO] = state_reg.diag_two;
        summary_word[BIT_DIAG_ONE] = state_reg.diag_one;
    end

    always_comb begin
        state_next = state_reg;

        // Level copy of the scan control indication
        state_next.scan_complete = scan_done_indication_i; // R1 R2

        // Only bit 14 is writable; every other written bit is dropped
        if (reg_wr_i && addr_hit && !reg_wdata_i[BIT_RESET_EVENT]) begin
            state_next.reset_event = 1'b0; // R4
        end

        if (acq_done_i) begin
            state_next.cell_mismatch = mismatch_cond; // R7
        end

        // Block alerts move only on a block acquisition
        if (block_acq_done_i) begin
            state_next.block_over = block_voltage_i > block_over_threshold_i; // R11 R13
            state_next.block_under = block_voltage_i < block_under_threshold_i; // R12 R13
        end

        // Owners of these alerts handle their own clearing
        state_next.packet_check = packet_check_alert_i; // R14
        state_next.interface_err = interface_error_alert_i; // R14
        state_next.calibration = calibration_fault_alert_i; // R14
        state_next.balancing = balancing_alert_i; // R14
        state_next.diag_two = |diag_group_two_register_i; // R16
        state_next.diag_one = |diag_group_one_register_i; // R16

        // Read data is captured one cycle after the request
        state_next.rvalid = reg_rd_i;
        if (reg_rd_i) begin
            state_next.rdata = addr_hit ? summary_word : RDATA_RESET;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= '{
                scan_complete: ALERT_RESET,
                reset_event: RESET_EVENT_RESET, // R3
                cell_mismatch: ALERT_RESET, // R18
                block_over: ALERT_RESET,
                block_under: ALERT_RESET,
                packet_check: ALERT_RESET,
                interface_err: ALERT_RESET,
                calibration: ALERT_RESET,
                balancing: ALERT_RESET,
                diag_two: ALERT_RESET,
                diag_one: ALERT_RESET,
                rvalid: 1'b0,
                rdata: RDATA_RESET
            };
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata_o = state_reg.rdata;
    assign reg_rvalid_o = state_reg.rvalid;
    assign primary_alert_summary_o = summary_word;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    // State is still held in reset on the releasing edge, so inputs must be quiet
    // there or the one-cycle follow properties below would see a missed update
    scan_set_a: assert property ( // R1
        scan_done_indication_i |=> primary_alert_summary_o[BIT_SCAN_COMPLETE])
        else $error("scan complete flag not set after scan done");
    scan_clear_a: assert property ( // R2
        !scan_done_indication_i |=> !primary_alert_summary_o[BIT_SCAN_COMPLETE])
        else $error("scan complete flag not cleared with scan done removed");
    reset_clear_a: assert property ( // R4
        reg_wr_i && addr_hit && !reg_wdata_i[BIT_RESET_EVENT]
        |=> !primary_alert_summary_o[BIT_RESET_EVENT])
        else $error("reset event flag not cleared by write of zero");
    reset_hold_a: assert property ( // R4
        primary_alert_summary_o[BIT_RESET_EVENT]
        && !(reg_wr_i && addr_hit && !reg_wdata_i[BIT_RESET_EVENT])
        |=> primary_alert_summary_o[BIT_RESET_EVENT])
        else $error("reset event flag changed without a write of zero");
    reset_no_set_a: assert property ( // R4
        !primary_alert_summary_o[BIT_RESET_EVENT]
        |=> !primary_alert_summary_o[BIT_RESET_EVENT])
        else $error("reset event flag set without a reset");
    mismatch_eval_a: assert property ( // R6
        acq_done_i |=> primary_alert_summary_o[BIT_CELL_MISMATCH] == $past(mismatch_cond))
        else $error("mismatch alert wrong after acquisition");
    mismatch_hold_a: assert property ( // R7
        !acq_done_i |=> $stable(primary_alert_summary_o[BIT_CELL_MISMATCH]))
        else $error("mismatch alert changed between acquisitions");
    block_over_a: assert property ( // R11
        block_acq_done_i |=> primary_alert_summary_o[BIT_BLOCK_OVER]
        == ($past(block_voltage_i) > $past(block_over_threshold_i)))
        else $error("block over alert wrong after block acquisition");
    block_under_a: assert property ( // R12
        block_acq_done_i |=> primary_alert_summary_o[BIT_BLOCK_UNDER]
        == ($past(block_voltage_i) < $past(block_under_threshold_i)))
        else $error("block under alert wrong after block acquisition");
    block_hold_a: assert property ( // R13
        !block_acq_done_i |=> $stable(primary_alert_summary_o[BIT_BLOCK_OVER:BIT_BLOCK_UNDER]))
        else $error("block alerts changed without block acquisition");

    // Channel summaries seen at the register, not only inside each latch
    cell_over_a: assert property ( // R8
        (|adc_cell_over_alerts_i) || (|comparator_cell_over_alerts_i)
        |=> primary_alert_summary_o[BIT_CELL_OVER])
        else $error("cell over summary missed an active source alert");
    cell_under_a: assert property ( // R9
        (|adc_cell_under_alerts_i) || (|comparator_cell_under_alerts_i)
        |=> primary_alert_summary_o[BIT_CELL_UNDER])
        else $error("cell under summary missed an active source alert");
    aux_over_a: assert property ( // R15
        (|adc_aux_over_alerts_i) || (|comparator_aux_over_alerts_i)
        |=> primary_alert_summary_o[BIT_AUX_OVER])
        else $error("aux over summary missed an active source alert");
    aux_under_a: assert property ( // R14
        (|adc_aux_under_alerts_i) || (|comparator_aux_under_alerts_i)
        |=> primary_alert_summary_o[BIT_AUX_UNDER])
        else $error("aux under summary missed an active source alert");
    diag_or_a: assert property ( // R16
        ##1 primary_alert_summary_o[BIT_DIAG_ONE] == (|$past(diag_group_one_register_i))
        && primary_alert_summary_o[BIT_DIAG_TWO] == (|$past(diag_group_two_register_i)))
        else $error("diagnostic summary not the OR of its register");
    group_copy_a: assert property ( // R14
        ##1 primary_alert_summary_o[BIT_PACKET_CHECK] == $past(packet_check_alert_i)
        && primary_alert_summary_o[BIT_BALANCING] == $past(balancing_alert_i))
        else $error("alert group summary does not follow its source");
    group_copy_two_a: assert property ( // R14
        ##1 primary_alert_summary_o[BIT_INTERFACE] == $past(interface_error_alert_i)
        && primary_alert_summary_o[BIT_CALIBRATION] == $past(calibration_fault_alert_i))
        else $error("interface or calibration summary does not follow its source");
    unused_zero_a: assert property (!primary_alert_summary_o[BIT_UNUSED]) // R17
        else $error("unused bit reads one");

    // Read data comes one cycle after the request and holds until the next read
    read_back_a: assert property (
        reg_rd_i && addr_hit |=> reg_rvalid_o && reg_rdata_o == $past(primary_alert_summary_o))
        else $error("read data does not match register contents");
    read_unmapped_a: assert property ( // R17
        reg_rd_i && !addr_hit |=> reg_rvalid_o && reg_rdata_o == RDATA_RESET)
        else $error("unmapped read returned nonzero data");
    rvalid_pulse_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("read valid without a read request");
    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read request");

    // Main scenarios a run should reach at least once
    scan_done_c: cover property (
        !primary_alert_summary_o[BIT_SCAN_COMPLETE] ##1 primary_alert_summary_o[BIT_SCAN_COMPLETE]);
    reset_cleared_c: cover property ($fell(primary_alert_summary_o[BIT_RESET_EVENT]));
    mismatch_set_c: cover property ($rose(primary_alert_summary_o[BIT_CELL_MISMATCH]));
    block_over_c: cover property ($rose(primary_alert_summary_o[BIT_BLOCK_OVER]));
    cell_over_clear_c: cover property ($fell(primary_alert_summary_o[BIT_CELL_OVER]));

endmodule : primary_alert_summary

`default_nettype wire

// ---- sim/host_link_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// Host end of the register link: each request is held for one full cycle
module host_link_model (
    // Clock
    input wire logic clk_sys_i,
    // Requests
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [15:0] wdata_o
);
    initial begin
        addr_o = 8'hff;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 16'h0000;
    end

    // The gap lets the host be slow as well as prompt
    task automatic access(input logic wr, input logic rd, input logic [7:0] a,
                          input logic [15:0] d, input int gap);
        @(posedge clk_sys_i);
        addr_o <= a;
        wr_o <= wr;
        rd_o <= rd;
        wdata_o <= d;
        @(posedge clk_sys_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        // Released lines show no stale request
        addr_o <= ~a;
        wdata_o <= ~d;
        repeat (gap) @(posedge clk_sys_i);
    endtask : access
endmodule : host_link_model

`default_nettype wire

// ---- sim/primary_alert_summary_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module primary_alert_summary_tb;
    import alert_summary_pkg::*;

    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic reg_rvalid;
    logic [15:0] reg_wdata, reg_rdata, summary, r, r2;
    logic scan = 1'b0, acq = 1'b0, bacq = 1'b0, rand_en = 1'b0;
    logic [13:0] cmax = 14'h0, cmin = 14'h0, thr = 14'h0;
    logic [14:1] aov = 14'h0, cov = 14'h0, auv = 14'h0, cuv = 14'h0;
    logic [5:0] axo = 6'h0, cxo = 6'h0, axu = 6'h0, cxu = 6'h0;
    logic [15:0] bv = 16'h0, bov = 16'h0, buv = 16'h0, d1 = 16'h0, d2 = 16'h0;
    logic [3:0] grp = 4'h0;
    logic [15:0] lfsr = 16'h004c;
    logic [15:0] exp_sum = 16'h4000, exp_rdata = 16'h0000;
    logic exp_rv = 1'b0;
    int mismatches = 0;
    int num_checks = 0;

    always #20 clk_sys_i = ~clk_sys_i;

    primary_alert_summary primary_alert_summary_inst (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
        .scan_done_indication_i(scan), .acq_done_i(acq),
        .cell_max_i(cmax), .cell_min_i(cmin), .mismatch_threshold_i(thr),
        .adc_cell_over_alerts_i(aov), .comparator_cell_over_alerts_i(cov),
        .adc_cell_under_alerts_i(auv), .comparator_cell_under_alerts_i(cuv),
        .adc_aux_over_alerts_i(axo), .comparator_aux_over_alerts_i(cxo),
        .adc_aux_under_alerts_i(axu), .comparator_aux_under_alerts_i(cxu),
        .block_acq_done_i(bacq), .block_voltage_i(bv),
        .block_over_threshold_i(bov), .block_under_threshold_i(buv),
        .packet_check_alert_i(grp[3]), .interface_error_alert_i(grp[2]),
        .calibration_fault_alert_i(grp[1]), .balancing_alert_i(grp[0]),
        .diag_group_one_register_i(d1), .diag_group_two_register_i(d2),
        .primary_alert_summary_o(summary)
    );

    host_link_model host_link_model_inst (
        .clk_sys_i(clk_sys_i), .addr_o(reg_addr), .wr_o(reg_wr), .rd_o(reg_rd),
        .wdata_o(reg_wdata)
    );

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : rnd

    // Mostly quiet sources, so that clearing at an acquisition really happens
    function automatic logic [13:0] sparse();
        logic [15:0] s;
        s = rnd();
        return (s[2:0] == 3'h0) ? 14'h0001 << (s[7:4] % 4'he) : 14'h0000;
    endfunction : sparse

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
        num_checks++;
        if (seen !== expv) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, expv, seen);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic acquire(input logic [13:0] mx, mn, th, input logic [15:0] v, ov, uv);
        @(posedge clk_sys_i);
        cmax <= mx;
        cmin <= mn;
        thr <= th;
        bv <= v;
        bov <= ov;
        buv <= uv;
        acq <= 1'b1;
        bacq <= 1'b1;
        @(posedge clk_sys_i);
        acq <= 1'b0;
        bacq <= 1'b0;
        // Measurements moving without a pulse must leave the alerts alone
        cmax <= ~mx;
        bv <= ~v;
    endtask : acquire

    // Reference model of the summary word and the read port
    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            exp_sum = 16'h4000;
            exp_rv = 1'b0;
            exp_rdata = 16'h0000;
        end else begin
            exp_rv = reg_rd;
            if (reg_rd) begin
                exp_rdata = (reg_addr == 8'h02) ? exp_sum : 16'h0000;
            end
            if (reg_wr && reg_addr == 8'h02 && !reg_wdata[14]) begin
                exp_sum[14] = 1'b0;
            end
            exp_sum[15] = scan;
            if (acq) begin
                exp_sum[13] = int'(cmax) - int'(cmin) > int'(thr);
            end
            exp_sum[12] = (|{aov, cov}) || (exp_sum[12] && !acq);
            exp_sum[11] = (|{auv, cuv}) || (exp_sum[11] && !acq);
            exp_sum[8] = (|{axo, cxo}) || (exp_sum[8] && !acq);
            exp_sum[7] = (|{axu, cxu}) || (exp_sum[7] && !acq);
            if (bacq) begin
                exp_sum[10] = bv > bov;
                exp_sum[9] = bv < buv;
            end
            exp_sum[5:2] = grp;
            exp_sum[1] = |d2;
            exp_sum[0] = |d1;
        end
    end

    always @(negedge clk_sys_i) begin
        check("summary", summary, exp_sum);
        check("rvalid", 16'(reg_rvalid), 16'(exp_rv));
        if (exp_rv) begin
            check("rdata", reg_rdata, exp_rdata);
        end
    end

    always @(posedge clk_sys_i) begin
        if (rand_en) begin
            r = rnd();
            acq <= r[1:0] == 2'h0;
            bacq <= r[3:2] == 2'h0;
            scan <= r[4];
            grp <= r[8:5];
            d1 <= r[9] ? 16'h0001 << r[13:10] : 16'h0000;
            d2 <= r[14] ? 16'h8000 >> r[13:10] : 16'h0000;
            aov <= sparse();
            cov <= sparse();
            auv <= sparse();
            cuv <= sparse();
            axo <= 6'(sparse());
            cxo <= 6'(sparse());
            axu <= 6'(sparse());
            cxu <= 6'(sparse());
            cmax <= 14'(rnd());
            cmin <= 14'(rnd());
            thr <= 14'(rnd() >> 4);
            bv <= rnd();
            bov <= rnd();
            buv <= rnd();
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(negedge clk_sys_i);
        check("reset value", summary, 16'h4000);
        host_link_model_inst.access(1'b1, 1'b0, 8'h02, 16'hffff, 0);
        host_link_model_inst.access(1'b1, 1'b0, 8'h03, 16'h0000, 0);
        host_link_model_inst.access(1'b0, 1'b1, 8'h05, 16'h0000, 1);
        host_link_model_inst.access(1'b1, 1'b1, 8'h02, 16'hbfff, 2);
        acquire(14'h64, 14'h28, 14'h3c, 16'h1f4, 16'h1f4, 16'h1f4);
        acquire(14'h64, 14'h28, 14'h3b, 16'h1f5, 16'h1f4, 16'h1f6);
        acquire(14'h28, 14'h64, 14'h0, 16'h1f4, 16'h1f4, 16'h1f4);
        @(posedge clk_sys_i);
        aov <= 14'h2000;
        @(posedge clk_sys_i);
        aov <= 14'h0;
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check("cell over held", 16'(summary[12]), 16'h0001);
        acquire(14'h0, 14'h0, 14'h0, 16'h0, 16'h0, 16'h0);
        rand_en <= 1'b1;
        repeat (600) begin
            r2 = rnd();
            host_link_model_inst.access(r2[0], r2[1], r2[2] ? 8'h02 : r2[15:8], rnd(),
                                        int'(r2[4:3]));
        end
        rand_en <= 1'b0;
        @(posedge clk_sys_i);
        // Sources go quiet first: the edge that releases reset still holds state in reset
        scan <= 1'b0;
        acq <= 1'b0;
        bacq <= 1'b0;
        grp <= 4'h0;
        d1 <= 16'h0000;
        d2 <= 16'h0000;
        aov <= 14'h0;
        cov <= 14'h0;
        auv <= 14'h0;
        cuv <= 14'h0;
        axo <= 6'h0;
        cxo <= 6'h0;
        axu <= 6'h0;
        cxu <= 6'h0;
        @(posedge clk_sys_i);
        rstn_i <= 1'b0;
        repeat (12) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(negedge clk_sys_i);
        check("reset again", summary, 16'h4000);
        host_link_model_inst.access(1'b1, 1'b0, 8'h02, 16'h0000, 1);
        @(negedge clk_sys_i);
        check("flag cleared", 16'(summary[14]), 16'h0000);
        test_done();
    end
endmodule : primary_alert_summary_tb

`default_nettype wire
